/* rtl/bbx_alu.sv */
// module: combinational 8-bit add and and with flags
`timescale 1ns/100ps
module bbx_alu #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] a,
    input wire logic [WIDTH-1:0] b,
    input wire logic sel_and,
    output logic [WIDTH-1:0] res,
    output logic carry,
    output logic dcarry,
    output logic zero
);
    logic [WIDTH:0] sum;
    logic [4:0] low_sum;

    // sum wraps, zero is exact 8-bit compare
    always_comb begin
        sum = {1'b0, a} + {1'b0, b};
        low_sum = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        res = sel_and ? (a & b) : sum[WIDTH-1:0];
        carry = sum[WIDTH];
        dcarry = low_sum[4];
        zero = (res == '0);
    end
endmodule

/* rtl/bbx_exec.sv */
// module: execute unit for add, and, bit set, bit skip and watchdog clear
//
// Contract
// - add-register sums working and file register, updates carry, digit carry, zero
// - destination bit zero writes working register, one writes file register
// - and-register ands working and file register, zero flag only
// - and-literal ands working register with literal into working register, zero only
// - bit-set forces selected bit to one, others kept, no flags
// - skip-if-clear discards next instruction when bit is zero, two cycles
// - skip-if-set discards next instruction when bit is one, two cycles
// - bit test and bit set never touch status flags
// - watchdog clear pulses watchdog_clear output for one cycle
// - watchdog clear sets timeout and power-down flags to one
// - read-modify-write on port register uses pin levels, not latch
`timescale 1ns/100ps
module bbx_exec #(
    parameter int NUM_FILE = 128
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic op_valid,
    input wire logic [2:0] op_code,
    input wire logic [6:0] file_addr,
    input wire logic dest_sel,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] literal,
    input wire logic [6:0] port_addr,
    input wire logic [7:0] port_pins,
    input wire logic timeout_evt,
    input wire logic sleep_evt,
    output logic busy,
    output logic skip_nop,
    output logic [7:0] w_reg,
    output logic carry_flag,
    output logic digit_carry_flag,
    output logic zero_flag,
    output logic timeout_flag_n,
    output logic powerdown_flag_n,
    output logic watchdog_clear,
    output logic port_wr,
    output logic [7:0] port_wr_data
);
    logic [7:0] file_q [NUM_FILE];
    logic [7:0] file_d [NUM_FILE];
    logic [7:0] w_q, w_d;
    logic c_q, c_d, dcy_q, dcy_d, z_q, z_d;
    logic tmo_n_q, tmo_n_d, pwdn_n_q, pwdn_n_d;
    logic wdc_q, wdc_d, pwr_q, pwr_d, skipn_q, skipn_d;
    logic [7:0] pwd_q, pwd_d;
    bbx_pkg::bbx_state_t st_q, st_d;
    logic [7:0] f_val, alu_b, alu_res, res, f_wr_val;
    logic alu_c, alu_dcy, alu_z, f_wr, is_port, tbit, accept;

    // port register reads its pins on read-modify-write
    always_comb begin
        is_port = (file_addr == port_addr);
        f_val = is_port ? port_pins : file_q[file_addr];
        alu_b = (op_code == bbx_pkg::OP_AND_LIT) ? literal : f_val;
        tbit = f_val[bit_sel];
    end

    bbx_alu #(
        .WIDTH(bbx_pkg::DATA_W)
    ) u_alu (
        .a(w_q),
        .b(alu_b),
        .sel_and(op_code != bbx_pkg::OP_ADD_REG),
        .res(alu_res),
        .carry(alu_c),
        .dcarry(alu_dcy),
        .zero(alu_z)
    );

    // operation decode and next state
    always_comb begin
        w_d = w_q;
        c_d = c_q;
        dcy_d = dcy_q;
        z_d = z_q;
        tmo_n_d = tmo_n_q;
        pwdn_n_d = pwdn_n_q;
        wdc_d = 1'b0;
        pwr_d = 1'b0;
        pwd_d = pwd_q;
        skipn_d = 1'b0;
        st_d = st_q;
        f_wr = 1'b0;
        f_wr_val = f_val;
        res = alu_res;
        accept = op_valid && (st_q == bbx_pkg::ST_EXEC);
        // external watchdog events; instruction below overrides
        if (timeout_evt) begin
            tmo_n_d = 1'b0;
        end
        if (sleep_evt) begin
            pwdn_n_d = 1'b0;
        end
        case (st_q)
            bbx_pkg::ST_NOP: begin
                st_d = bbx_pkg::ST_EXEC; // discarded slot runs as nop
            end
            default: begin
                st_d = bbx_pkg::ST_EXEC;
            end
        endcase
        if (accept) begin
            case (op_code)
                bbx_pkg::OP_ADD_REG: begin
                    c_d = alu_c;
                    dcy_d = alu_dcy;
                    z_d = alu_z;
                end
                bbx_pkg::OP_AND_REG: begin
                    z_d = alu_z;
                end
                bbx_pkg::OP_AND_LIT: begin
                    w_d = alu_res;
                    z_d = alu_z;
                end
                bbx_pkg::OP_BIT_SET: begin
                    res = f_val | (8'h01 << bit_sel);
                    f_wr = 1'b1;
                    f_wr_val = res;
                end
                bbx_pkg::OP_SKIP_CLR: begin
                    if (!tbit) begin
                        st_d = bbx_pkg::ST_NOP;
                        skipn_d = 1'b1;
                    end
                end
                bbx_pkg::OP_SKIP_SET: begin
                    if (tbit) begin
                        st_d = bbx_pkg::ST_NOP;
                        skipn_d = 1'b1;
                    end
                end
                bbx_pkg::OP_WATCHDOG_CLR: begin
                    wdc_d = 1'b1;
                    tmo_n_d = 1'b1;
                    pwdn_n_d = 1'b1;
                end
                default: begin
                end
            endcase
            // destination select for register-operand ops
            if (op_code == bbx_pkg::OP_ADD_REG || op_code == bbx_pkg::OP_AND_REG) begin
                if (dest_sel) begin
                    f_wr = 1'b1;
                    f_wr_val = alu_res;
                end else begin
                    w_d = alu_res;
                end
            end
        end
        if (f_wr && is_port) begin
            pwr_d = 1'b1;
            pwd_d = f_wr_val;
        end
    end

    // file register next values, one per entry
    for (genvar i = 0; i < NUM_FILE; i++) begin : g_file
        always_comb begin
            file_d[i] = file_q[i];
            if (f_wr && (file_addr == 7'(i))) begin
                file_d[i] = f_wr_val;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NUM_FILE; i++) begin
                file_q[i] <= bbx_pkg::FILE_RST;
            end
        end else begin
            for (int i = 0; i < NUM_FILE; i++) begin
                file_q[i] <= file_d[i];
            end
        end
    end

    // working register, flags, strobes, state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            w_q <= bbx_pkg::W_RST;
            c_q <= 1'b0;
            dcy_q <= 1'b0;
            z_q <= 1'b0;
            tmo_n_q <= bbx_pkg::STAT_N_RST;
            pwdn_n_q <= bbx_pkg::STAT_N_RST;
            wdc_q <= 1'b0;
            pwr_q <= 1'b0;
            pwd_q <= 8'h00;
            skipn_q <= 1'b0;
            st_q <= bbx_pkg::ST_EXEC;
        end else begin
            w_q <= w_d;
            c_q <= c_d;
            dcy_q <= dcy_d;
            z_q <= z_d;
            tmo_n_q <= tmo_n_d;
            pwdn_n_q <= pwdn_n_d;
            wdc_q <= wdc_d;
            pwr_q <= pwr_d;
            pwd_q <= pwd_d;
            skipn_q <= skipn_d;
            st_q <= st_d;
        end
    end

    // outputs straight from flops, busy decoded from st_q
    assign w_reg = w_q;
    assign carry_flag = c_q;
    assign digit_carry_flag = dcy_q;
    assign zero_flag = z_q;
    assign timeout_flag_n = tmo_n_q;
    assign powerdown_flag_n = pwdn_n_q;
    assign watchdog_clear = wdc_q;
    assign port_wr = pwr_q;
    assign port_wr_data = pwd_q;
    assign skip_nop = skipn_q;
    assign busy = (st_q == bbx_pkg::ST_NOP);

    a_add_sum: assert property (@(posedge clk) disable iff (!nrst)
        (op_valid && !busy && op_code == bbx_pkg::OP_ADD_REG && !dest_sel && !is_port)
        |=> (w_reg == 8'($past(w_q) + $past(file_q[file_addr]))))
        else $error("add result wrong");
    a_add_zero: assert property (@(posedge clk) disable iff (!nrst)
        (op_valid && !busy && op_code == bbx_pkg::OP_ADD_REG)
        |=> (zero_flag == (8'($past(w_q) + $past(f_val)) == 8'h00)))
        else $error("zero flag wrong");
    a_dest_file: assert property (@(posedge clk) disable iff (!nrst)
        (op_valid && !busy && op_code == bbx_pkg::OP_AND_REG && dest_sel)
        |=> $stable(w_reg))
        else $error("destination file changed w");
    a_andlit_res: assert property (@(posedge clk) disable iff (!nrst)
        (op_valid && !busy && op_code == bbx_pkg::OP_AND_LIT)
        |=> (w_reg == ($past(w_q) & $past(literal))) && $stable(carry_flag))
        else $error("and literal wrong");
    a_and_flags: assert property (@(posedge clk) disable iff (!nrst)
        (op_valid && !busy && op_code == bbx_pkg::OP_AND_REG)
        |=> $stable(carry_flag) && $stable(digit_carry_flag))
        else $error("and touched carry");
    a_bitop_flags: assert property (@(posedge clk) disable iff (!nrst)
        (op_valid && !busy && (op_code == bbx_pkg::OP_BIT_SET
        || op_code == bbx_pkg::OP_SKIP_CLR || op_code == bbx_pkg::OP_SKIP_SET))
        |=> $stable(zero_flag) && $stable(carry_flag) && $stable(digit_carry_flag))
        else $error("bit op touched flags");
    a_skip_clr: assert property (@(posedge clk) disable iff (!nrst)
        (op_valid && !busy && op_code == bbx_pkg::OP_SKIP_CLR && !tbit)
        |=> skip_nop && busy ##1 !busy)
        else $error("skip if clear wrong");
    a_skip_set: assert property (@(posedge clk) disable iff (!nrst)
        (op_valid && !busy && op_code == bbx_pkg::OP_SKIP_SET)
        |=> (busy == $past(tbit)))
        else $error("skip if set wrong");
    a_watchdog_clear: assert property (@(posedge clk) disable iff (!nrst)
        (op_valid && !busy && op_code == bbx_pkg::OP_WATCHDOG_CLR)
        |=> watchdog_clear && timeout_flag_n && powerdown_flag_n
        ##1 (!watchdog_clear || $past(accept && op_code == bbx_pkg::OP_WATCHDOG_CLR)))
        else $error("watchdog clear wrong");
    a_watchdog_flags: assert property (@(posedge clk) disable iff (!nrst)
        (op_valid && !busy && op_code == bbx_pkg::OP_WATCHDOG_CLR)
        |=> timeout_flag_n && powerdown_flag_n)
        else $error("status flags not set");
endmodule

/* rtl/bbx_pkg.sv */
// package: constants for the byte and bit operation execute unit
package bbx_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int BIT_W = 3;
    localparam int OP_W = 3;
    localparam logic [2:0] OP_NONE = 3'h0;
    localparam logic [2:0] OP_ADD_REG = 3'h1;
    localparam logic [2:0] OP_AND_REG = 3'h2;
    localparam logic [2:0] OP_AND_LIT = 3'h3;
    localparam logic [2:0] OP_BIT_SET = 3'h4;
    localparam logic [2:0] OP_SKIP_CLR = 3'h5;
    localparam logic [2:0] OP_SKIP_SET = 3'h6;
    localparam logic [2:0] OP_WATCHDOG_CLR = 3'h7;
    localparam logic [7:0] W_RST = 8'h00;
    localparam logic [7:0] FILE_RST = 8'h00;
    localparam logic STAT_N_RST = 1'h1;
    localparam int NUM_CYC_SKIP = 2;
    typedef enum logic [1:0] {
        ST_EXEC = 2'b01,
        ST_NOP = 2'b10
    } bbx_state_t;
endpackage

/* tb/byte_bit_op_execute_tb_top.sv */
// testbench: self-checking scenarios for the byte and bit operation execute unit
`timescale 1ns/100ps
module byte_bit_op_execute_tb_top;
    logic clk, nrst, op_valid, dest_sel, timeout_evt, sleep_evt;
    logic [2:0] op_code, bit_sel;
    logic [6:0] file_addr, port_addr;
    logic [7:0] literal, port_pins, w_reg, port_wr_data;
    logic busy, skip_nop, carry_flag, digit_carry_flag, zero_flag;
    logic timeout_flag_n, powerdown_flag_n, watchdog_clear, port_wr;
    int n_fail = 0;
    int n_compared = 0;
    int cycles = 0;

    bbx_exec DUT (.clk(clk), .nrst(nrst), .op_valid(op_valid), .op_code(op_code),
        .file_addr(file_addr), .dest_sel(dest_sel), .bit_sel(bit_sel), .literal(literal),
        .port_addr(port_addr), .port_pins(port_pins), .timeout_evt(timeout_evt),
        .sleep_evt(sleep_evt), .busy(busy), .skip_nop(skip_nop), .w_reg(w_reg),
        .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag),
        .timeout_flag_n(timeout_flag_n), .powerdown_flag_n(powerdown_flag_n),
        .watchdog_clear(watchdog_clear), .port_wr(port_wr), .port_wr_data(port_wr_data));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // hang guard, well above the length of all scenarios
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_fail++;
            test_done();
        end
    end

    task automatic test_done();
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            n_fail++;
        end
    endtask

    // carry, digit carry, zero packed low
    function automatic logic [7:0] fl();
        return {5'h00, carry_flag, digit_carry_flag, zero_flag};
    endfunction

    // presents one operation at the falling edge; valid is held for back-to-back use
    task automatic op(input logic [2:0] c, input logic [6:0] a, input logic d,
                      input logic [2:0] b, input logic [7:0] k);
        op_code = c;
        file_addr = a;
        dest_sel = d;
        bit_sel = b;
        literal = k;
        op_valid = 1'b1;
        @(negedge clk);
    endtask

    task automatic idle();
        op_valid = 1'b0;
        @(negedge clk);
    endtask

    // one operation, then working register and flags judged
    task automatic step(input logic [2:0] c, input logic [6:0] a, input logic d,
                        input logic [2:0] b, input logic [7:0] k, input logic [7:0] ew,
                        input logic [7:0] ef);
        op(c, a, d, b, k);
        chk("w_reg", ew, w_reg);
        chk("flags", ef, fl());
    endtask

    // bit set builds operands, then add and and walk through carries, wrap and zero
    task automatic t_alu();
        for (int b = 0; b < 7; b++) begin
            step(bbx_pkg::OP_BIT_SET, 7'h0A, 1'b0, b[2:0], 8'h00, 8'h00, 8'h00);
        end
        op(bbx_pkg::OP_BIT_SET, 7'h14, 1'b1, 3'h0, 8'h00);
        op(bbx_pkg::OP_BIT_SET, 7'h14, 1'b0, 3'h7, 8'h00);
        chk("port_wr", 8'h00, {7'h00, port_wr});
        step(bbx_pkg::OP_ADD_REG, 7'h0A, 1'b0, 3'h0, 8'h00, 8'h7F, 8'h00);
        step(bbx_pkg::OP_ADD_REG, 7'h0A, 1'b1, 3'h0, 8'h00, 8'h7F, 8'h02);
        step(bbx_pkg::OP_ADD_REG, 7'h0A, 1'b0, 3'h0, 8'h00, 8'h7D, 8'h06);
        step(bbx_pkg::OP_AND_LIT, 7'h00, 1'b0, 3'h0, 8'h0F, 8'h0D, 8'h06);
        step(bbx_pkg::OP_AND_REG, 7'h0A, 1'b1, 3'h0, 8'h00, 8'h0D, 8'h06);
        step(bbx_pkg::OP_AND_REG, 7'h14, 1'b0, 3'h0, 8'h00, 8'h01, 8'h06);
        step(bbx_pkg::OP_AND_LIT, 7'h00, 1'b0, 3'h0, 8'h00, 8'h00, 8'h07);
        step(bbx_pkg::OP_ADD_REG, 7'h1E, 1'b0, 3'h0, 8'h00, 8'h00, 8'h01);
        step(bbx_pkg::OP_ADD_REG, 7'h0A, 1'b0, 3'h0, 8'h00, 8'h0C, 8'h00);
    endtask

    // bit test on 0x81; a taken skip swallows the op offered in the lost slot
    task automatic t_skip(input logic [2:0] c, input logic [2:0] b, input logic exp);
        op(c, 7'h14, 1'b0, b, 8'h00);
        chk("busy", {7'h00, exp}, {7'h00, busy});
        chk("skip_nop", {7'h00, exp}, {7'h00, skip_nop});
        chk("flags", 8'h00, fl());
        if (exp) begin
            op(bbx_pkg::OP_AND_LIT, 7'h00, 1'b0, 3'h0, 8'h00);
            chk("w_reg", 8'h0C, w_reg);
            chk("busy", 8'h00, {7'h00, busy});
        end
    endtask

    // port address reads the pins, not the stored value
    task automatic t_port();
        step(bbx_pkg::OP_ADD_REG, 7'h40, 1'b0, 3'h0, 8'h00, 8'hB1, 8'h02);
        op(bbx_pkg::OP_BIT_SET, 7'h40, 1'b0, 3'h1, 8'h00);
        chk("port_wr", 8'h01, {7'h00, port_wr});
        chk("port_wr_data", 8'hA7, port_wr_data);
    endtask

    // events drop both status flags, watchdog clear raises them again
    task automatic t_watchdog();
        idle();
        timeout_evt = 1'b1;
        sleep_evt = 1'b1;
        @(negedge clk);
        timeout_evt = 1'b0;
        sleep_evt = 1'b0;
        chk("status_n", 8'h00, {6'h00, timeout_flag_n, powerdown_flag_n});
        op(bbx_pkg::OP_WATCHDOG_CLR, 7'h00, 1'b0, 3'h0, 8'h00);
        chk("watchdog_clear", 8'h01, {7'h00, watchdog_clear});
        chk("status_n", 8'h03, {6'h00, timeout_flag_n, powerdown_flag_n});
        idle();
        chk("watchdog_clear", 8'h00, {7'h00, watchdog_clear});
        chk("status_n", 8'h03, {6'h00, timeout_flag_n, powerdown_flag_n});
    endtask

    // main sequence
    initial begin
        nrst = 1'b0;
        op_valid = 1'b0;
        op_code = 3'h0;
        file_addr = 7'h00;
        dest_sel = 1'b0;
        bit_sel = 3'h0;
        literal = 8'h00;
        port_addr = 7'h40;
        port_pins = 8'hA5;
        timeout_evt = 1'b0;
        sleep_evt = 1'b0;
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        chk("w_reg", 8'h00, w_reg);
        chk("flags", 8'h00, fl());
        chk("status_n", 8'h03, {6'h00, timeout_flag_n, powerdown_flag_n});
        chk("busy", 8'h00, {7'h00, busy});
        t_alu();
        t_skip(bbx_pkg::OP_SKIP_CLR, 3'h1, 1'b1);
        t_skip(bbx_pkg::OP_SKIP_CLR, 3'h0, 1'b0);
        t_skip(bbx_pkg::OP_SKIP_SET, 3'h7, 1'b1);
        t_skip(bbx_pkg::OP_SKIP_SET, 3'h1, 1'b0);
        t_port();
        t_watchdog();
        idle();
        test_done();
    end
endmodule
